// ### sfuec_pkg.sv
// Overview of operation
// - Code 0ch with mask bit 15 and select 01h counts packed double uops.
// - Each selected packed double uop of an instruction adds one count.
// - Code 0ah with mask bit 15 counts scalar single uops.
// - Uops not selected by the event mask leave the counter unchanged.
// - Each selected scalar single uop of an instruction counts separately.
// - Code 0eh with mask bit 15 and select 01h counts scalar double uops.
// - Each selected scalar double uop of an instruction adds one.
// - Code 02h with mask bit 15 counts 64-bit SIMD integer uops.
// - Each selected 64-bit SIMD integer uop counts separately.
// - A separate 128-bit SIMD integer event is provided.
// - Code 1ah with mask bit 15 counts each 128-bit uop separately.
// - First selector drives counters 8 and 9, second drives 10 and 11.
package sfuec_pkg;
   localparam int unsigned LANES      = 4;
   localparam int unsigned CLS_W      = 3;
   localparam int unsigned DW         = 32;
   localparam int unsigned AW         = 8;
   localparam int unsigned NUM_CNT    = 4;
   localparam int unsigned SECOND_IDX = 2;
   localparam int unsigned FIRST_NUM  = 8;

   localparam logic [7:0] OFS_SEL_FIRST  = 8'h00;
   localparam logic [7:0] OFS_SEL_SECOND = 8'h04;
   localparam logic [7:0] OFS_CFG_BASE   = 8'h10;
   localparam logic [7:0] OFS_CNT_BASE   = 8'h20;

   localparam int unsigned SEL_CODE_HI  = 31;
   localparam int unsigned SEL_CODE_LO  = 25;
   localparam int unsigned SEL_MASK_HI  = 24;
   localparam int unsigned SEL_MASK_LO  = 9;
   localparam int unsigned SEL_MASK_ALL = 24;
   localparam int unsigned CFG_SEL_HI   = 15;
   localparam int unsigned CFG_SEL_LO   = 13;
   localparam int unsigned CFG_EN_BIT   = 12;

   localparam logic [2:0] CFG_SEL_VAL = 3'h1;

   localparam logic [6:0] EV_PACKED_DP = 7'h0c;
   localparam logic [6:0] EV_SCALAR_SP = 7'h0a;
   localparam logic [6:0] EV_SCALAR_DP = 7'h0e;
   localparam logic [6:0] EV_SIMD64    = 7'h02;
   localparam logic [6:0] EV_SIMD128   = 7'h1a;

   localparam logic [31:0] SEL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      SFUEC_NONE      = 3'h0,
      SFUEC_PACKED_DP = 3'h1,
      SFUEC_SCALAR_SP = 3'h2,
      SFUEC_SCALAR_DP = 3'h3,
      SFUEC_SIMD64    = 3'h4,
      SFUEC_SIMD128   = 3'h5
   } sfuec_class_e;

   // Maps a programmed event code to the uop class that it counts.
   function automatic sfuec_class_e sfuec_code_class(input logic [6:0] code);
      case (code)
         EV_PACKED_DP: sfuec_code_class = SFUEC_PACKED_DP;
         EV_SCALAR_SP: sfuec_code_class = SFUEC_SCALAR_SP;
         EV_SCALAR_DP: sfuec_code_class = SFUEC_SCALAR_DP;
         EV_SIMD64:    sfuec_code_class = SFUEC_SIMD64;
         EV_SIMD128:   sfuec_code_class = SFUEC_SIMD128;
         default:      sfuec_code_class = SFUEC_NONE;
      endcase
   endfunction : sfuec_code_class
endpackage : sfuec_pkg

// ### sfuec_counter.sv
`timescale 1ns/1ps
module sfuec_counter import sfuec_pkg::*; (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic [DW-1:0]          sel_i,
   input  wire logic [DW-1:0]          cfg_i,
   input  wire logic [LANES-1:0]       lane_valid_i,
   input  wire logic [LANES*CLS_W-1:0] lane_class_i,
   input  wire logic                   wr_i,
   input  wire logic [DW-1:0]          wr_data_i,
   output      logic [DW-1:0]          count_o
);
   sfuec_class_e     target_w;
   logic             armed_w;
   logic [LANES-1:0] hit_w;
   logic [2:0]       nhit_w;
   logic [DW-1:0]    count_d;
   logic [DW-1:0]    count_q;

   assign target_w = sfuec_code_class(sel_i[SEL_CODE_HI:SEL_CODE_LO]);
   // Unmasked uops, a wrong select or an unknown code count nothing.
   assign armed_w = cfg_i[CFG_EN_BIT]
                  && (cfg_i[CFG_SEL_HI:CFG_SEL_LO] == CFG_SEL_VAL)
                  && sel_i[SEL_MASK_ALL]
                  && (target_w != SFUEC_NONE);

   // Every lane is one uop; several lanes of one instruction add up.
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign hit_w[l] = armed_w && lane_valid_i[l]
         && (lane_class_i[l*CLS_W +: CLS_W] == target_w);
   end

   always_comb begin
      nhit_w = 3'h0;
      for (int i = 0; i < LANES; i++) begin
         nhit_w = nhit_w + {2'h0, hit_w[i]};
      end
   end

   // A software write takes precedence over the increment in that cycle.
   assign count_d = wr_i ? wr_data_i : count_q + {29'h0, nhit_w};

   always_ff @(posedge clk_i) begin
      if (rst_i) count_q <= CNT_RST;
      else       count_q <= count_d;
   end

   assign count_o = count_q;
endmodule : sfuec_counter

// ### sfuec_event_counter.sv
`timescale 1ns/1ps
module sfuec_event_counter import sfuec_pkg::*; (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [AW-1:0]          wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [DW-1:0]          wb_dat_i,
   output      logic [DW-1:0]          wb_dat_o,
   output      logic                   wb_ack_o,
   input  wire logic [LANES-1:0]       uop_valid_i,
   input  wire logic [LANES*CLS_W-1:0] uop_class_i
);
   ////////////////////////////////////////////////////////////////////////
   // Register bus decode.

   logic          ack_q;
   logic [DW-1:0] rdata_q;
   logic [DW-1:0] sel_first_q;
   logic [DW-1:0] sel_second_q;
   logic [DW-1:0] cfg_q  [NUM_CNT];
   logic [DW-1:0] cnt_w  [NUM_CNT];
   logic [NUM_CNT-1:0] cfg_hit_w;
   logic [NUM_CNT-1:0] cnt_hit_w;
   logic [NUM_CNT-1:0] cnt_wr_w;
   logic          req_w;
   logic          wr_w;
   logic          sel_first_hit_w;
   logic          sel_second_hit_w;
   logic [DW-1:0] rd_mux_w;

   // Applies the Wishbone byte enables to one register word.
   function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old,
                                              input logic [DW-1:0] nw,
                                              input logic [3:0]    be);
      logic [DW-1:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
      end
      return r;
   endfunction : be_merge

   // One access is taken per request; the ack cycle itself takes nothing.
   assign req_w = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_w  = req_w && wb_we_i;

   assign sel_first_hit_w  = (wb_adr_i == OFS_SEL_FIRST);
   assign sel_second_hit_w = (wb_adr_i == OFS_SEL_SECOND);

   for (genvar i = 0; i < NUM_CNT; i++) begin : g_dec
      assign cfg_hit_w[i] = (wb_adr_i == OFS_CFG_BASE + 8'(4 * i));
      assign cnt_hit_w[i] = (wb_adr_i == OFS_CNT_BASE + 8'(4 * i));
      assign cnt_wr_w[i]  = wr_w && cnt_hit_w[i];
   end

   // Unmapped addresses read as zero and ignore writes.
   always_comb begin
      rd_mux_w = 32'h0000_0000;
      if (sel_first_hit_w) begin
         rd_mux_w = sel_first_q;
      end else if (sel_second_hit_w) begin
         rd_mux_w = sel_second_q;
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (cfg_hit_w[i]) rd_mux_w = cfg_q[i];
            if (cnt_hit_w[i]) rd_mux_w = cnt_w[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q   <= req_w;
         rdata_q <= req_w ? rd_mux_w : rdata_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Event selection and counter configuration registers.

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_first_q  <= SEL_RST;
         sel_second_q <= SEL_RST;
      end else begin
         if (wr_w && sel_first_hit_w)
            sel_first_q <= be_merge(sel_first_q, wb_dat_i, wb_sel_i);
         if (wr_w && sel_second_hit_w)
            sel_second_q <= be_merge(sel_second_q, wb_dat_i, wb_sel_i);
      end
   end

   for (genvar i = 0; i < NUM_CNT; i++) begin : g_cfg
      always_ff @(posedge clk_i) begin
         if (rst_i)
            cfg_q[i] <= CFG_RST;
         else if (wr_w && cfg_hit_w[i])
            cfg_q[i] <= be_merge(cfg_q[i], wb_dat_i, wb_sel_i);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counters; the low pair follows the first selector, the high pair the
   // second, and no configuration can route them otherwise.

   for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      logic [DW-1:0] sel_w;
      assign sel_w = (i < SECOND_IDX) ? sel_first_q
                                      : sel_second_q;
      sfuec_counter u_cnt (
         .clk_i        (clk_i),
         .rst_i        (rst_i),
         .sel_i        (sel_w),
         .cfg_i        (cfg_q[i]),
         .lane_valid_i (uop_valid_i),
         .lane_class_i (uop_class_i),
         .wr_i         (cnt_wr_w[i]),
         .wr_data_i    (be_merge(cnt_w[i], wb_dat_i, wb_sel_i)),
         .count_o      (cnt_w[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   // Counts the valid lanes of one class, independently of the counters.
   function automatic logic [2:0] n_class(input logic [LANES-1:0] v,
                                          input logic [LANES*CLS_W-1:0] c,
                                          input sfuec_class_e k);
      logic [2:0] n;
      n = 3'h0;
      for (int l = 0; l < LANES; l++) begin
         if (v[l] && (k != SFUEC_NONE) && (c[l*CLS_W +: CLS_W] == k))
            n = n + 3'h1;
      end
      return n;
   endfunction : n_class

   logic [6:0] code0_w;
   logic       cfg_ok0_w;
   logic       cfg_ok1_w;
   logic       arm0_w;
   logic       arm1_w;
   logic       arm2_w;
   logic [2:0] n_pdp_w;
   logic [2:0] n_ssp_w;
   logic [2:0] n_sdp_w;
   logic [2:0] n_s64_w;
   logic [2:0] n_s128_w;
   logic [2:0] n_tgt0_w;
   logic [6:0] code1_w;
   logic       arm3_w;
   logic       any_hit_w;
   logic [2:0] n_tgt1_w;

   assign code0_w   = sel_first_q[SEL_CODE_HI:SEL_CODE_LO];
   assign code1_w   = sel_second_q[SEL_CODE_HI:SEL_CODE_LO];
   // Any mapped register; everything else must read as zero.
   assign any_hit_w = sel_first_hit_w || sel_second_hit_w
                   || (|cfg_hit_w) || (|cnt_hit_w);
   assign cfg_ok0_w = cfg_q[0][CFG_EN_BIT]
                   && (cfg_q[0][CFG_SEL_HI:CFG_SEL_LO] == CFG_SEL_VAL);
   assign cfg_ok1_w = cfg_q[1][CFG_EN_BIT]
                   && (cfg_q[1][CFG_SEL_HI:CFG_SEL_LO] == CFG_SEL_VAL);
   assign arm0_w    = cfg_ok0_w && sel_first_q[SEL_MASK_ALL];
   assign arm1_w    = cfg_ok1_w && sel_first_q[SEL_MASK_ALL];
   assign arm2_w    = cfg_q[2][CFG_EN_BIT]
                   && (cfg_q[2][CFG_SEL_HI:CFG_SEL_LO] == CFG_SEL_VAL)
                   && sel_second_q[SEL_MASK_ALL];
   assign n_pdp_w   = n_class(uop_valid_i, uop_class_i, SFUEC_PACKED_DP);
   assign n_ssp_w   = n_class(uop_valid_i, uop_class_i, SFUEC_SCALAR_SP);
   assign n_sdp_w   = n_class(uop_valid_i, uop_class_i, SFUEC_SCALAR_DP);
   assign n_s64_w   = n_class(uop_valid_i, uop_class_i, SFUEC_SIMD64);
   assign n_s128_w  = n_class(uop_valid_i, uop_class_i, SFUEC_SIMD128);
   assign n_tgt0_w  = n_class(uop_valid_i, uop_class_i,
                              sfuec_code_class(code0_w));
   assign n_tgt1_w  = n_class(uop_valid_i, uop_class_i,
                              sfuec_code_class(code1_w));
   assign arm3_w    = cfg_q[3][CFG_EN_BIT]
                   && (cfg_q[3][CFG_SEL_HI:CFG_SEL_LO] == CFG_SEL_VAL)
                   && sel_second_q[SEL_MASK_ALL];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ack_one_cycle: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stayed high for more than one cycle");

   chk_ack_latency: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   chk_cfg_write: assert property (
      wr_w && cfg_hit_w[0] && (wb_sel_i == 4'hf)
      |=> cfg_q[0] == $past(wb_dat_i))
      else $error("configuration write was lost");

   chk_packed_double: assert property (
      arm0_w && code0_w == EV_PACKED_DP && !cnt_wr_w[0]
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'($past(n_pdp_w)))
      else $error("packed double uops miscounted");

   chk_scalar_single: assert property (
      arm0_w && code0_w == EV_SCALAR_SP && !cnt_wr_w[0]
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'($past(n_ssp_w)))
      else $error("scalar single uops miscounted");

   chk_scalar_double: assert property (
      arm0_w && code0_w == EV_SCALAR_DP && !cnt_wr_w[0]
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'($past(n_sdp_w)))
      else $error("scalar double uops miscounted");

   chk_simd64_count: assert property (
      arm0_w && code0_w == EV_SIMD64 && !cnt_wr_w[0]
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'($past(n_s64_w)))
      else $error("64-bit SIMD uops miscounted");

   chk_simd128_count: assert property (
      arm0_w && code0_w == EV_SIMD128 && !cnt_wr_w[0]
      |=> cnt_w[0] == $past(cnt_w[0]) + 32'($past(n_s128_w)))
      else $error("128-bit SIMD uops miscounted");

   chk_mask_clear_hold: assert property (
      !sel_first_q[SEL_MASK_ALL] && !cnt_wr_w[0]
      |=> $stable(cnt_w[0]))
      else $error("counter moved with the mask bit clear");

   chk_first_pair: assert property (
      arm1_w && !cnt_wr_w[1]
      |=> cnt_w[1] == $past(cnt_w[1]) + 32'($past(n_tgt0_w)))
      else $error("second counter of the low pair miscounted");

   chk_second_isolated: assert property (
      !arm2_w && !cnt_wr_w[2] |=> $stable(cnt_w[2]))
      else $error("high pair counted without its own selector");

   // The high pair counts the class named by the second selector only.
   chk_high_pair: assert property (
      arm2_w && !cnt_wr_w[2]
      |=> cnt_w[2] == $past(cnt_w[2]) + 32'($past(n_tgt1_w)))
      else $error("first counter of the high pair miscounted");

   chk_high_second: assert property (
      arm3_w && !cnt_wr_w[3]
      |=> cnt_w[3] == $past(cnt_w[3]) + 32'($past(n_tgt1_w)))
      else $error("second counter of the high pair miscounted");

   chk_unknown_code: assert property (
      sfuec_code_class(code1_w) == SFUEC_NONE && !cnt_wr_w[2]
      |=> $stable(cnt_w[2]))
      else $error("counter moved on an unknown event code");

   chk_bad_select: assert property (
      cfg_q[3][CFG_SEL_HI:CFG_SEL_LO] != CFG_SEL_VAL && !cnt_wr_w[3]
      |=> $stable(cnt_w[3]))
      else $error("counter moved with a wrong configuration select");

   chk_disabled_hold: assert property (
      !cfg_q[2][CFG_EN_BIT] && !cnt_wr_w[2] |=> $stable(cnt_w[2]))
      else $error("disabled counter moved");

   // Register writes land at the taking edge; byte enables are honoured.
   chk_count_write: assert property (
      cnt_wr_w[0] && (wb_sel_i == 4'hf) |=> cnt_w[0] == $past(wb_dat_i))
      else $error("counter write was lost");

   chk_high_write: assert property (
      cnt_wr_w[2] && (wb_sel_i == 4'hf) |=> cnt_w[2] == $past(wb_dat_i))
      else $error("high pair counter write was lost");

   chk_sel_write: assert property (
      wr_w && sel_first_hit_w && (wb_sel_i == 4'hf)
      |=> sel_first_q == $past(wb_dat_i))
      else $error("first selector write was lost");

   chk_second_sel_write: assert property (
      wr_w && sel_second_hit_w && (wb_sel_i == 4'hf)
      |=> sel_second_q == $past(wb_dat_i))
      else $error("second selector write was lost");

   chk_cfg_bytes: assert property (
      wr_w && cfg_hit_w[1] && (wb_sel_i == 4'h3)
      |=> cfg_q[1][15:0] == $past(wb_dat_i[15:0])
          && cfg_q[1][31:16] == $past(cfg_q[1][31:16]))
      else $error("byte enables not applied to a configuration write");

   // Read data is the word seen at the taking edge and then holds.
   chk_read_select: assert property (
      req_w && !wb_we_i && sel_first_hit_w
      |=> wb_dat_o == $past(sel_first_q))
      else $error("selector read returned the wrong word");

   chk_read_count: assert property (
      req_w && !wb_we_i && cnt_hit_w[0] |=> wb_dat_o == $past(cnt_w[0]))
      else $error("counter read returned the wrong word");

   chk_unmapped_read: assert property (
      req_w && !wb_we_i && !any_hit_w |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped address did not read as zero");

   chk_ack_needs_req: assert property (
      wb_ack_o |-> $past(req_w))
      else $error("ack without a taken request");

   chk_rdata_hold: assert property (
      !req_w |=> $stable(wb_dat_o))
      else $error("read data changed without a request");

   cov_four_lanes: cover property (
      arm0_w && code0_w == EV_PACKED_DP && n_pdp_w == 3'h4);
   cov_simd128: cover property (
      arm0_w && code0_w == EV_SIMD128 && n_s128_w != 3'h0);
   cov_read_counter: cover property (
      req_w && !wb_we_i && cnt_hit_w[0] ##1 wb_ack_o);
   cov_both_pairs: cover property (arm0_w && arm2_w);
endmodule : sfuec_event_counter

// ### sfuec_uop_source.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Pipeline stand-in that reports up to four decoded uops each cycle.
module sfuec_uop_source (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic [31:0] rnd_i,
   output      logic [3:0]  uop_valid_o,
   output      logic [11:0] uop_class_o
);
   // While disabled, all lanes keep toggling their class so stale classes never look valid.
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         uop_valid_o <= 4'h0;
         uop_class_o <= rst_i ? 12'h5a5 : ~uop_class_o;
      end else begin
         uop_valid_o <= rnd_i[3:0];
         for (int l = 0; l < 4; l++) begin
            uop_class_o[3*l +: 3] <= rnd_i[4+4*l +: 3];
         end
      end
   end
endmodule : sfuec_uop_source

// ### sfuec_event_counter_tb.sv
`timescale 1ns/1ps
module sfuec_event_counter_tb import sfuec_pkg::*;;
   logic        clk_i, rst_i, cyc, stb, we, en, ack;
   logic [7:0]  adr;
   logic [3:0]  sel, uv;
   logic [11:0] uc;
   logic [31:0] wdat, rdat, rnd;
   logic [31:0] mir [16];
   logic [6:0]  codes [5] = '{7'h0c, 7'h0a, 7'h0e, 7'h02, 7'h1a};
   int          bad_count, check_count;

   sfuec_event_counter sfuec_event_counter_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .uop_valid_i(uv), .uop_class_i(uc));
   sfuec_uop_source sfuec_uop_source_i (
      .clk_i(clk_i), .rst_i(rst_i), .en_i(en), .rnd_i(rnd),
      .uop_valid_o(uv), .uop_class_o(uc));

   //////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function automatic int cls(input logic [6:0] c);
      case (c)
         7'h0c: cls = 1;
         7'h0a: cls = 2;
         7'h0e: cls = 3;
         7'h02: cls = 4;
         7'h1a: cls = 5;
         default: cls = 0;
      endcase
   endfunction : cls

   function automatic bit hit(input logic [7:0] a);
      hit = a[1:0] == 2'h0 && a < 8'h30 && a[5:2] != 4'h2 && a[5:2] != 4'h3;
   endfunction : hit

   always @(posedge clk_i) rnd <= lfsr(rnd);

   // Reference counters live in mir[8..11]; they only change on a hit so a
   // bus task writing the mirror at the same edge is never overwritten.
   always @(posedge clk_i) begin
      if (rst_i === 1'b0) begin
         for (int i = 0; i < 4; i++) begin
            int h;
            int k;
            h = 0;
            k = cls(mir[i>>1][31:25]);
            for (int l = 0; l < 4; l++) begin
               if (uv[l] === 1'b1 && int'(uc[3*l +: 3]) == k && k != 0) h++;
            end
            if (mir[4+i][15:12] === 4'h3 && mir[i>>1][24] === 1'b1 && h != 0)
               mir[8+i] += 32'(h);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] g,
                      input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= b;
      // Only the watchdog ends a wait for an answer that never comes.
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
      logic [31:0] q, m;
      bus(a, 1'b1, d, b, q);
      m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      if (hit(a)) mir[a[5:2]] = (mir[a[5:2]] & ~m) | (d & m);
   endtask : wr

   task automatic rdc(input logic [7:0] a);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, 4'hf, q);
      chk($sformatf("reg %h", a), q, hit(a) ? mir[a[5:2]] : 32'h0);
   endtask : rdc

   task automatic final_report;
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      final_report();
   end

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, en} = 4'h0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      rnd = 32'hf5dbc221;
      bad_count = 0;
      check_count = 0;
      for (int i = 0; i < 16; i++) mir[i] = 32'h0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a < 64; a += 4) rdc(8'(a));
      for (int k = 0; k < 6; k++) begin
         // The last pass selects a non-ALL mask bit and an unknown code.
         wr(8'h00, {codes[k%5], k == 5 ? 16'h4000 : 16'h8000, 9'h0}, 4'hf);
         wr(8'h04, {k == 5 ? 7'h04 : codes[(k+2)%5], 16'h8000, 9'h0}, 4'hf);
         for (int i = 0; i < 4; i++) begin
            // Odd passes write whole words; pass 2 disables counter 2.
            wr(8'(8'h10 + 4*i), 32'ha5a5_0000 |
               ((k == 3 && i == 3) ? 32'h5000 :
                (k == 2 && i == 2) ? 32'h2000 : 32'h3000),
               (k % 2 == 1) ? 4'hf : 4'h3);
            wr(8'(8'h20 + 4*i), k == 4 ? 32'hffff_fff8 : 32'(k*i), 4'hf);
         end
         wr(8'h08, 32'hffff_ffff, 4'hf);
         en <= 1'b1;
         repeat (40) @(posedge clk_i);
         en <= 1'b0;
         repeat (2) @(posedge clk_i);
         for (int a = 0; a < 64; a += 4) begin
            rdc(8'(a));
            // Same reads
         end
      end
      final_report();
   end
endmodule : sfuec_event_counter_tb
